// ===== testbench/sfa_core_model.sv
// Purpose: core-side model reaching the alu over axi4-lite
// Assumes: one request at a time, signals move after a rising edge
// Notes: every wait is bounded; a wait that runs out bumps hangs
`timescale 1ns/10ps
module sfa_core_model
  import sfa_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // write side
  output logic [SFA_ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read side
  output logic [SFA_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int hangs = 0; // waits that used up their bound
  // idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (!(s_axi_awready && s_axi_wready) && ++n < 200);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_bvalid && ++n < 400);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200) hangs++;
  endtask
  // single read, rready held until rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready && ++n < 200);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid && ++n < 400);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200) hangs++;
  endtask
  // mode change, then let it reach the datapath before any use
  task automatic set_mode(input logic [31:0] m);
    logic [1:0] r;
    wr(SFA_CTRL_OFS, m, r);
    repeat (MODE_SETTLE_CYC + 1) @(posedge ref_clk);
  endtask
endmodule

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the saturating fractional alu
// Assumes: 40 MHz ref_clk, nrst held low for 12 cycles
// Notes: divides are only issued with nonzero divisors that fit
`timescale 1ns/10ps
module tb_top
  import sfa_pkg::*;
;
  logic ref_clk = 1'b0, nrst = 1'b0, wake_pin = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, stop_state, wait_state;
  int bad_count = 0; // mismatches
  int num_checks = 0; // comparisons
  always #12.5 ref_clk = ~ref_clk;
  // device under test
  sfa_alu uut (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wake_pin,
    .stop_state, .wait_state);
  // core side bus master
  sfa_core_model core (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // load operands, issue, poll done (bounded), compare result
  task automatic op(input logic [4:0] c, input logic [31:0] a, b, input logic acc,
                    input logic [31:0] e);
    logic [1:0] r;
    logic [31:0] d;
    int n;
    core.wr(SFA_OPA_OFS, a, r);
    core.wr(SFA_OPB_OFS, b, r);
    core.wr(SFA_CMD_OFS, {23'h0, acc, 3'h0, c}, r);
    for (n = 0; n < 80; n++) begin
      core.rd(SFA_STATUS_OFS, d, r);
      if (d[SFA_ST_DONE_BIT] === 1'b1) break;
    end
    if (n >= 80) core.hangs++;
    if (core.hangs != 0) complete_run(); // a stuck bus or poll ends the run at once
    core.rd(SFA_RESULT_OFS, d, r);
    chk($sformatf("result of op %h", c), e, d);
  endtask
  // reset value of mode, unmapped place refused
  task automatic t_bus;
    logic [1:0] r;
    logic [31:0] d;
    core.rd(SFA_CTRL_OFS, d, r);
    chk("ctrl reset", 32'h0, d);
    core.wr(8'h3c, 32'h1234_5678, r);
    chk("bresp", {30'h0, SFA_RESP_SLVERR}, {30'h0, r});
    core.rd(8'h3c, d, r);
    chk("rresp", {30'h0, SFA_RESP_SLVERR}, {30'h0, r});
  endtask
  // wrap with limiter off, clamp by sign with it on
  task automatic t_addsub;
    op(OP_ADD16, 32'h0000_7fff, 32'h0000_0001, 1'b0, 32'hffff_8000);
    op(OP_SUB32, 32'h8000_0000, 32'h0000_0001, 1'b0, 32'h7fff_ffff);
    core.set_mode(32'h1);
    op(OP_ADD16, 32'h0000_4000, 32'h0000_2000, 1'b0, 32'h0000_6000);
    op(OP_ADD16, 32'h0000_7fff, 32'h0000_0001, 1'b0, 32'h0000_7fff);
    op(OP_SUB16, 32'h0000_8000, 32'h0000_0001, 1'b0, 32'hffff_8000);
    op(OP_SUB16, 32'h0000_4000, 32'h0000_e000, 1'b0, 32'h0000_6000);
    op(OP_ADD32, 32'h7fff_ffff, 32'h0000_0001, 1'b0, 32'h7fff_ffff);
    op(OP_SUB32, 32'h8000_0000, 32'h0000_0001, 1'b0, 32'h8000_0000);
  endtask
  // magnitude and negation incl. most negative inputs
  task automatic t_absneg;
    op(OP_ABS16, 32'h0000_e000, 32'h0, 1'b0, 32'h0000_2000);
    op(OP_ABS16, 32'h0000_8000, 32'h0, 1'b0, 32'h0000_7fff);
    op(OP_NEG16, 32'h0000_2000, 32'h0, 1'b0, 32'hffff_e000);
    op(OP_NEG16, 32'h0000_8000, 32'h0, 1'b0, 32'h0000_7fff);
    op(OP_ABS32, 32'he000_0000, 32'h0, 1'b0, 32'h2000_0000);
    op(OP_ABS32, 32'h8000_0000, 32'h0, 1'b0, 32'h7fff_ffff);
    op(OP_NEG32, 32'he000_0000, 32'h0, 1'b0, 32'h2000_0000);
    op(OP_NEG32, 32'h8000_0000, 32'h0, 1'b0, 32'h7fff_ffff);
  endtask
  // halves out with and without accumulator target, halves in without
  task automatic t_extdep;
    op(OP_EXT_HI, 32'h8765_4321, 32'h0, 1'b0, 32'hffff_8765);
    op(OP_EXT_HI, 32'h8765_4321, 32'h0, 1'b1, 32'h8765_0000);
    op(OP_EXT_LO, 32'h8765_4321, 32'h0, 1'b0, 32'h0000_4321);
    op(OP_EXT_LO, 32'h8765_4321, 32'h0, 1'b1, 32'h4321_0000);
    op(OP_DEP_HI, 32'h0000_3fff, 32'h0, 1'b0, 32'h3fff_0000);
    op(OP_DEP_LO, 32'h0000_8001, 32'h0, 1'b0, 32'hffff_8001);
  endtask
  // ties: to even when convergent, upward when twos-complement
  task automatic t_round;
    op(OP_ROUND, 32'h0001_8000, 32'h0, 1'b0, 32'h0000_0002);
    op(OP_ROUND, 32'h0002_8000, 32'h0, 1'b0, 32'h0000_0002);
    core.set_mode(32'h3);
    op(OP_ROUND, 32'h0002_8000, 32'h0, 1'b0, 32'h0000_0003);
  endtask
  // quotients as fractions of 2^-15 / 2^-31, every quadrant
  task automatic t_div;
    op(OP_QUOT_POS_SHORT, 32'h0000_2000, 32'h0000_4000, 1'b0, 32'h0000_4000);
    op(OP_QUOT_POS_SHORT, 32'h0000_4000, 32'h0000_4000, 1'b0, 32'h0000_7fff);
    op(OP_QUOT_POS_LONG, 32'h2000_0000, 32'h0000_4000, 1'b0, 32'h0000_4000);
    op(OP_QUOT_POS_LONG, 32'h4000_0000, 32'h0000_4000, 1'b0, 32'h0000_7fff);
    op(OP_QUOT_SGN_SHORT, 32'h0000_e000, 32'h0000_c000, 1'b0, 32'h0000_4000);
    op(OP_QUOT_SGN_SHORT, 32'h0000_2000, 32'h0000_c000, 1'b0, 32'hffff_c000);
    op(OP_QUOT_SGN_LONG, 32'he000_0000, 32'h0000_c000, 1'b0, 32'h0000_4000);
    op(OP_QUOT_SGN_LONG, 32'he000_0000, 32'h0000_4000, 1'b0, 32'hffff_c000);
  endtask
  // stop left by wake pin, wait left by a new command
  task automatic t_lowpow;
    logic [1:0] r;
    logic [31:0] d;
    int n;
    core.wr(SFA_CMD_OFS, {27'h0, OP_STOP}, r);
    for (n = 0; n < 20 && stop_state !== 1'b1; n++) @(posedge ref_clk);
    chk("stop_state", 32'h1, {31'h0, stop_state});
    core.rd(SFA_STATUS_OFS, d, r);
    chk("status stop", 32'h1, {31'h0, d[SFA_ST_STOP_BIT]});
    wake_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wake_pin <= 1'b0;
    for (n = 0; n < 20 && stop_state !== 1'b0; n++) @(posedge ref_clk);
    chk("stop cleared", 32'h0, {31'h0, stop_state});
    core.wr(SFA_CMD_OFS, {27'h0, OP_WAIT}, r);
    for (n = 0; n < 20 && wait_state !== 1'b1; n++) @(posedge ref_clk);
    chk("wait_state", 32'h1, {31'h0, wait_state});
    op(OP_ABS16, 32'h0000_0005, 32'h0, 1'b0, 32'h0000_0005);
    chk("wait cleared", 32'h0, {31'h0, wait_state});
  endtask
  // verdict and end of run
  task automatic complete_run;
    bad_count += core.hangs;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    t_bus();
    t_addsub();
    t_absneg();
    t_extdep();
    t_round();
    t_div();
    t_lowpow();
    complete_run();
  end
endmodule

// ===== verilog/sfa_alu.sv
// Purpose: saturating fractional alu with axi4-lite register access
// Assumes: one clock ref_clk at 40 MHz, nrst asynchronous active low
// Notes: division is sequential, 32 steps; other ops finish in one cycle
//
// Contract
// - abs16 returns |x|, 0x8000 gives 0x7fff
// - neg16 returns -x, 0x8000 gives 0x7fff
// - abs32 returns |x|, 0x80000000 saturates
// - neg32 returns -x, 0x80000000 saturates
// - add16 sums, clamps when saturation enabled
// - sub16 a minus b, clamps when enabled
// - add32 sums, saturates when enabled
// - sub32 a minus b, saturates when enabled
// - saturation bit enables output limiter clamping
// - rounding bit clear convergent, set twos-complement
// - stop and wait enter low-power states
// - high extract, no saturation, accumulator low zeroed
// - low extract, no saturation, accumulator low zeroed
// - high deposit, lower sixteen bits zero
// - low deposit, upper bits sign extended
// - positive short divide, equal gives 0x7fff
// - positive long divide, equal gives 0x7fff
// - signed short divide, correctly signed quotient; a negated quotient past 0x8000 in magnitude wraps unclamped
// - signed long divide, correctly signed quotient; a negated quotient past 0x8000 in magnitude wraps unclamped
// - fractions scale by 2^-15 and 2^-31
`timescale 1ns/10ps
module sfa_alu
  import sfa_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic [SFA_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [SFA_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // low-power state pins
  input wire logic wake_pin,
  output logic stop_state,
  output logic wait_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // word-aligned register decode, shared by read and write paths
  function automatic logic reg_known(input logic [SFA_ADDR_W-1:0] a);
    logic [SFA_ADDR_W-1:0] w;
    w = {a[SFA_ADDR_W-1:2], 2'b00};
    reg_known = (w == SFA_CTRL_OFS) || (w == SFA_OPA_OFS) || (w == SFA_OPB_OFS) ||
                (w == SFA_CMD_OFS) || (w == SFA_RESULT_OFS) || (w == SFA_STATUS_OFS);
  endfunction

  // merge write data into a word under byte strobes
  function automatic logic [31:0] strobe_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    strobe_merge = r;
  endfunction

  // clamp a 17-bit true result into 16 bits when enabled
  function automatic logic [15:0] sat16(input logic [16:0] v, input logic en);
    if (en && (v[16] != v[15])) begin
      sat16 = v[16] ? SAT16_MIN : SAT16_MAX;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // clamp a 33-bit true result into 32 bits when enabled
  function automatic logic [31:0] sat32(input logic [32:0] v, input logic en);
    if (en && (v[32] != v[31])) begin
      sat32 = v[32] ? SAT32_MIN : SAT32_MAX;
    end else begin
      sat32 = v[31:0];
    end
  endfunction

  // place a 16-bit result: accumulator form zeroes the low portion
  function automatic logic [31:0] pack16(input logic [15:0] v, input logic acc);
    pack16 = acc ? {v, 16'h0000} : {{16{v[15]}}, v};
  endfunction

  // register state
  logic [1:0] ctrl_q; // mode bits as written
  logic [31:0] opa_q; // first operand / numerator
  logic [31:0] opb_q; // second operand / denominator
  logic [4:0] op_q; // latched opcode
  logic acc_q; // destination is an accumulator
  logic start_q; // one-cycle pulse after a command write
  logic [31:0] result_q; // result register
  logic done_q; // last command has finished
  logic stop_q; // low-power stop state
  logic wait_q; // low-power wait state
  logic bvalid_q;
  logic rvalid_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [1:0] mode_pipe_q [MODE_SETTLE_CYC]; // mode settle delay line
  logic wake_s1_q; // synchroniser, first stage
  logic wake_s2_q; // synchroniser, second stage
  sfa_state_type state_q;
  logic [5:0] step_q; // divide step counter
  logic [16:0] rem_q; // partial remainder
  logic [31:0] quo_q; // dividend shifting out, quotient shifting in
  logic [16:0] dvs_q; // doubled divisor magnitude
  logic neg_q; // quotient must be negated

  // handshakes: write address and data are taken together
  logic wr_go;
  logic cmd_wr;
  logic busy;
  logic sat_eff; // saturation mode as seen by the datapath
  logic rnd_eff; // rounding mode as seen by the datapath
  logic [SFA_ADDR_W-1:0] waddr;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !rvalid_q;
  assign waddr = {s_axi_awaddr[SFA_ADDR_W-1:2], 2'b00};
  assign busy = (state_q == SFA_DIV);
  // commands arriving while a divide runs are dropped
  assign cmd_wr = wr_go && (waddr == SFA_CMD_OFS) && s_axi_wstrb[0] && !busy;
  assign sat_eff = mode_pipe_q[MODE_SETTLE_CYC-1][SFA_CTRL_SAT_BIT];
  assign rnd_eff = mode_pipe_q[MODE_SETTLE_CYC-1][SFA_CTRL_RND_BIT];
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign stop_state = stop_q;
  assign wait_state = wait_q;

  // write response channel
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q <= SFA_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= reg_known(s_axi_awaddr) ? SFA_RESP_OKAY : SFA_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // software-writable registers; result and status are read-only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= SFA_CTRL_RESET;
      opa_q <= 32'h0000_0000;
      opb_q <= 32'h0000_0000;
    end else if (wr_go) begin
      if (waddr == SFA_CTRL_OFS && s_axi_wstrb[0]) begin
        ctrl_q <= s_axi_wdata[SFA_CTRL_RND_BIT:SFA_CTRL_SAT_BIT];
      end
      if (waddr == SFA_OPA_OFS) begin
        opa_q <= strobe_merge(opa_q, s_axi_wdata, s_axi_wstrb);
      end
      if (waddr == SFA_OPB_OFS) begin
        opb_q <= strobe_merge(opb_q, s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  // command capture; start pulses for exactly one cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      op_q <= OP_ABS16;
      acc_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= cmd_wr;
      if (cmd_wr) begin
        op_q <= s_axi_wdata[SFA_CMD_OP_LSB +: SFA_CMD_OP_W];
        acc_q <= s_axi_wdata[SFA_CMD_ACC_BIT];
      end
    end
  end

  // mode bits reach the limiter and rounder only after the settle delay,
  // which is why the core must write them ahead of use
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < MODE_SETTLE_CYC; i++) begin
        mode_pipe_q[i] <= SFA_CTRL_RESET;
      end
    end else begin
      mode_pipe_q[0] <= ctrl_q;
      for (int i = 1; i < MODE_SETTLE_CYC; i++) begin
        mode_pipe_q[i] <= mode_pipe_q[i-1];
      end
    end
  end

  // wake pin synchroniser
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= wake_pin;
      wake_s2_q <= wake_s1_q;
    end
  end

  // single-cycle datapath
  logic [15:0] a16;
  logic [15:0] b16;
  logic [16:0] sum17;
  logic [16:0] dif17;
  logic [32:0] sum33;
  logic [32:0] dif33;
  logic [32:0] rnd33;
  logic [31:0] alu_out;
  assign a16 = opa_q[15:0];
  assign b16 = opb_q[15:0];
  assign sum17 = {a16[15], a16} + {b16[15], b16};
  assign dif17 = {a16[15], a16} - {b16[15], b16};
  assign sum33 = {opa_q[31], opa_q} + {opb_q[31], opb_q};
  assign dif33 = {opa_q[31], opa_q} - {opb_q[31], opb_q};
  // twos-complement rounding adds one half; convergent clears the lsb on a tie
  always_comb begin
    rnd33 = {opa_q[31], opa_q} + RND_HALF;
    if (!rnd_eff && opa_q[15:0] == RND_TIE) begin
      rnd33[16] = 1'b0;
    end
  end

  // result selection by opcode
  always_comb begin
    unique case (op_q)
      OP_ABS16: alu_out = pack16((a16 == SAT16_MIN) ? SAT16_MAX :
                                 (a16[15] ? (~a16 + 16'h0001) : a16), acc_q);
      OP_NEG16: alu_out = pack16((a16 == SAT16_MIN) ? SAT16_MAX :
                                 (~a16 + 16'h0001), acc_q);
      OP_ABS32: alu_out = (opa_q == SAT32_MIN) ? SAT32_MAX :
                          (opa_q[31] ? (~opa_q + 32'h0000_0001) : opa_q);
      OP_NEG32: alu_out = (opa_q == SAT32_MIN) ? SAT32_MAX :
                          (~opa_q + 32'h0000_0001);
      OP_ADD16: alu_out = pack16(sat16(sum17, sat_eff), acc_q);
      OP_SUB16: alu_out = pack16(sat16(dif17, sat_eff), acc_q);
      OP_ADD32: alu_out = sat32(sum33, sat_eff);
      OP_SUB32: alu_out = sat32(dif33, sat_eff);
      OP_EXT_HI: alu_out = pack16(opa_q[31:16], acc_q);
      OP_EXT_LO: alu_out = pack16(opa_q[15:0], acc_q);
      OP_DEP_HI: alu_out = {a16, 16'h0000};
      OP_DEP_LO: alu_out = {{16{a16[15]}}, a16};
      OP_ROUND: alu_out = pack16(sat16(rnd33[32:16], sat_eff), acc_q);
      default: alu_out = result_q; // divides, power ops and unknown codes
    endcase
  end

  // divider setup: fractional quotient q = num / (2 * den) after scaling
  // a short numerator by 2^16, which matches the 2^-15 / 2^-31 formats
  logic is_div;
  logic is_sgn;
  logic is_long;
  logic [15:0] num16_mag;
  logic [31:0] num_mag;
  logic [15:0] den_mag;
  logic [16:0] step_try;
  logic [17:0] step_sh;
  logic [15:0] quot16;
  logic step_bit; // quotient bit won by this step
  logic [31:0] quo_next; // quotient word after this step
  assign is_div = (op_q == OP_QUOT_POS_SHORT) || (op_q == OP_QUOT_POS_LONG) ||
                  (op_q == OP_QUOT_SGN_SHORT) || (op_q == OP_QUOT_SGN_LONG);
  assign is_sgn = (op_q == OP_QUOT_SGN_SHORT) || (op_q == OP_QUOT_SGN_LONG);
  assign is_long = (op_q == OP_QUOT_POS_LONG) || (op_q == OP_QUOT_SGN_LONG);
  assign num16_mag = (is_sgn && a16[15]) ? (~a16 + 16'h0001) : a16;
  assign num_mag = is_long ? ((is_sgn && opa_q[31]) ? (~opa_q + 32'h0000_0001) : opa_q)
                           : {num16_mag, 16'h0000};
  assign den_mag = (is_sgn && b16[15]) ? (~b16 + 16'h0001) : b16;
  assign step_sh = {rem_q, quo_q[31]};
  assign step_try = step_sh[16:0] - dvs_q;
  assign step_bit = (step_sh >= {1'b0, dvs_q});
  assign quo_next = {quo_q[30:0], step_bit};
  // no zero-divisor check; a positive quotient above 0x7fff clamps to 0x7fff, a negated one is taken as it lands
  assign quot16 = neg_q ? (~quo_next[15:0] + 16'h0001) :
                  ((quo_next > {16'h0000, SAT16_MAX}) ? SAT16_MAX : quo_next[15:0]);

  // sequencer: one-cycle ops finish at once, divides walk 32 steps
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SFA_IDLE;
      step_q <= 6'h00;
      rem_q <= 17'h0_0000;
      quo_q <= 32'h0000_0000;
      dvs_q <= 17'h0_0000;
      neg_q <= 1'b0;
    end else begin
      unique case (state_q)
        SFA_IDLE: begin
          if (start_q && is_div) begin
            state_q <= SFA_DIV;
            step_q <= 6'h00;
            rem_q <= 17'h0_0000;
            quo_q <= num_mag;
            dvs_q <= {den_mag, 1'b0};
            // sign of quotient from the operand signs
            neg_q <= is_sgn && ((is_long ? opa_q[31] : a16[15]) ^ b16[15]);
          end
        end
        SFA_DIV: begin
          // restoring step; the shifted remainder never exceeds 18 bits
          if (step_bit) begin
            rem_q <= step_try;
          end else begin
            rem_q <= step_sh[16:0];
          end
          quo_q <= quo_next;
          step_q <= step_q + 6'h01;
          if (step_q == DIV_LAST) begin
            state_q <= SFA_IDLE;
          end
        end
      endcase
    end
  end

  // result and done flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end else if (state_q == SFA_DIV && step_q == DIV_LAST) begin
      // last quotient bit arrives with this edge, so fold it in here
      result_q <= pack16(quot16, acc_q);
      done_q <= 1'b1;
    end else if (start_q && !is_div) begin
      result_q <= alu_out;
      done_q <= 1'b1;
    end else if (cmd_wr) begin
      done_q <= 1'b0;
    end
  end

  // low-power states: entered by command, left by wake or a new command;
  // entry wins when both land in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stop_q <= 1'b0;
      wait_q <= 1'b0;
    end else if (start_q && op_q == OP_STOP) begin
      stop_q <= 1'b1;
      wait_q <= 1'b0;
    end else if (start_q && op_q == OP_WAIT) begin
      wait_q <= 1'b1;
      stop_q <= 1'b0;
    end else if (wake_s2_q || cmd_wr) begin
      stop_q <= 1'b0;
      wait_q <= 1'b0;
    end
  end

  // read channel; data is registered one cycle after the address
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rresp_q <= SFA_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= reg_known(s_axi_araddr) ? SFA_RESP_OKAY : SFA_RESP_SLVERR;
      rdata_q <= 32'h0000_0000;
      unique case ({s_axi_araddr[SFA_ADDR_W-1:2], 2'b00})
        SFA_CTRL_OFS: rdata_q[SFA_CTRL_RND_BIT:SFA_CTRL_SAT_BIT] <= ctrl_q;
        SFA_OPA_OFS: rdata_q <= opa_q;
        SFA_OPB_OFS: rdata_q <= opb_q;
        SFA_CMD_OFS: rdata_q <= {23'h00_0000, acc_q, 3'h0, op_q};
        SFA_RESULT_OFS: rdata_q <= result_q;
        SFA_STATUS_OFS: rdata_q <= {27'h000_0000, (ctrl_q == mode_pipe_q[MODE_SETTLE_CYC-1]),
                                    wait_q, stop_q, done_q, busy};
        default: rdata_q <= 32'h0000_0000; // unmapped reads zero
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  abs16_limit_a: assert property (start_q && op_q == OP_ABS16 && a16 == 16'h8000 && !acc_q
    |=> result_q == 32'h0000_7fff) else $error("abs16 of most negative not clamped");
  neg16_limit_a: assert property (start_q && op_q == OP_NEG16 && a16 == 16'h8000 && !acc_q
    |=> result_q == 32'h0000_7fff) else $error("neg16 of most negative not clamped");
  abs32_limit_a: assert property (start_q && op_q == OP_ABS32 && opa_q == 32'h8000_0000
    |=> result_q == 32'h7fff_ffff) else $error("abs32 of most negative not clamped");
  neg32_value_a: assert property (start_q && op_q == OP_NEG32 && opa_q != 32'h8000_0000
    |=> result_q == -$past(opa_q)) else $error("neg32 result wrong");
  add16_clamp_a: assert property (start_q && op_q == OP_ADD16 && sat_eff && !acc_q &&
    !a16[15] && !b16[15] && sum17[15] |=> result_q == 32'h0000_7fff)
    else $error("add16 overflow not clamped");
  sub32_wrap_a: assert property (start_q && op_q == OP_SUB32 && !sat_eff
    |=> result_q == $past(opa_q) - $past(opb_q)) else $error("sub32 wrap wrong");
  mode_settle_a: assert property ($rose(ctrl_q[SFA_CTRL_SAT_BIT])
    ##1 ctrl_q[SFA_CTRL_SAT_BIT] [*2]
    |=> sat_eff) else $error("saturation mode did not settle in 3 cycles");
  ext_hi_acc_a: assert property (start_q && op_q == OP_EXT_HI && acc_q
    |=> result_q == {$past(opa_q[31:16]), 16'h0000}) else $error("extract high wrong");
  dep_lo_a: assert property (start_q && op_q == OP_DEP_LO
    |=> result_q == {{16{$past(a16[15])}}, $past(a16)}) else $error("deposit low wrong");
  div_done_a: assert property (start_q && is_div && state_q == SFA_IDLE
    |-> ##33 (done_q && state_q == SFA_IDLE)) else $error("divide not done in 33 cycles");
  stop_enter_a: assert property (start_q && op_q == OP_STOP
    |=> stop_state && !wait_state) else $error("stop state not entered");

endmodule

// ===== verilog/sfa_pkg.sv
// Purpose: shared constants for the saturating fractional alu
// Assumes: 32-bit axi4-lite register bus, byte addresses below
// Notes: opcodes are the values software writes into the command register
package sfa_pkg;
  // bus geometry
  localparam int unsigned SFA_ADDR_W = 8;
  localparam logic [1:0] SFA_RESP_OKAY = 2'b00;
  localparam logic [1:0] SFA_RESP_SLVERR = 2'b10;
  // register byte offsets
  localparam logic [7:0] SFA_CTRL_OFS = 8'h00;
  localparam logic [7:0] SFA_OPA_OFS = 8'h04;
  localparam logic [7:0] SFA_OPB_OFS = 8'h08;
  localparam logic [7:0] SFA_CMD_OFS = 8'h0c;
  localparam logic [7:0] SFA_RESULT_OFS = 8'h10;
  localparam logic [7:0] SFA_STATUS_OFS = 8'h14;
  // operating_mode_register fields (ctrl register)
  localparam int unsigned SFA_CTRL_SAT_BIT = 0;
  localparam int unsigned SFA_CTRL_RND_BIT = 1;
  localparam logic [1:0] SFA_CTRL_RESET = 2'h0;
  // command register fields
  localparam int unsigned SFA_CMD_OP_LSB = 0;
  localparam int unsigned SFA_CMD_OP_W = 5;
  localparam int unsigned SFA_CMD_ACC_BIT = 8;
  // status register fields
  localparam int unsigned SFA_ST_BUSY_BIT = 0;
  localparam int unsigned SFA_ST_DONE_BIT = 1;
  localparam int unsigned SFA_ST_STOP_BIT = 2;
  localparam int unsigned SFA_ST_WAIT_BIT = 3;
  localparam int unsigned SFA_ST_SETTLED_BIT = 4;
  // opcodes
  localparam logic [4:0] OP_ABS16 = 5'h00;
  localparam logic [4:0] OP_NEG16 = 5'h01;
  localparam logic [4:0] OP_ABS32 = 5'h02;
  localparam logic [4:0] OP_NEG32 = 5'h03;
  localparam logic [4:0] OP_ADD16 = 5'h04;
  localparam logic [4:0] OP_SUB16 = 5'h05;
  localparam logic [4:0] OP_ADD32 = 5'h06;
  localparam logic [4:0] OP_SUB32 = 5'h07;
  localparam logic [4:0] OP_EXT_HI = 5'h08;
  localparam logic [4:0] OP_EXT_LO = 5'h09;
  localparam logic [4:0] OP_DEP_HI = 5'h0a;
  localparam logic [4:0] OP_DEP_LO = 5'h0b;
  localparam logic [4:0] OP_QUOT_POS_SHORT = 5'h0c;
  localparam logic [4:0] OP_QUOT_POS_LONG = 5'h0d;
  localparam logic [4:0] OP_QUOT_SGN_SHORT = 5'h0e;
  localparam logic [4:0] OP_QUOT_SGN_LONG = 5'h0f;
  localparam logic [4:0] OP_ROUND = 5'h10;
  localparam logic [4:0] OP_STOP = 5'h11;
  localparam logic [4:0] OP_WAIT = 5'h12;
  // saturation limits and rounding constants
  localparam logic [15:0] SAT16_MAX = 16'h7fff;
  localparam logic [15:0] SAT16_MIN = 16'h8000;
  localparam logic [31:0] SAT32_MAX = 32'h7fff_ffff;
  localparam logic [31:0] SAT32_MIN = 32'h8000_0000;
  localparam logic [32:0] RND_HALF = 33'h0_0000_8000;
  localparam logic [15:0] RND_TIE = 16'h8000;
  // timing: mode bits take this many cycles to reach the datapath
  localparam int unsigned MODE_SETTLE_CYC = 3;
  localparam logic [5:0] DIV_LAST = 6'h1f;
  // sequencer states
  typedef enum logic {SFA_IDLE, SFA_DIV} sfa_state_type;
endpackage
